// File: include/pmvt_pkg.sv
// Constants, types and encodings for the program sequencer.
// Assumes one 50 MHz core clock and a synchronous one-cycle ROM outside.
// Overview of operation
// - Program memory is 8K words of 16 bits and holds both vectors, user code and a reserved tail.
// - The reset vector is the single word at address zero, the first one run after any reset.
// - Power-on gives timeout 1 / power-down 0, watchdog 0 / 0, external reset 1 / 1.
// - Any reset loads the program counter with zero and every register with its default.
// - Both reset-cause flags can be read as bits of the processor flag register.
// - Taking an interrupt pushes the program counter and continues at word address eight.
// - One interrupt vector word serves every interrupt source alike.
// - Save copies accumulator and flags to a shadow, restore copies them back, cause bits untouched.
// - The shadow is one level deep, so a second save overwrites the first.
// - The table read addresses ROM with upper index bits 0-4 as bits 8-12 and the lower index as bits 0-7.
// - The table read puts the low byte in the accumulator and the high byte in the result register.
// - Incrementing the lower index past 0xFF wraps it and leaves the upper index alone.
package pmvt_pkg;
    localparam int PM_WORDS = 8192;
    localparam int ADDR_W = $clog2(PM_WORDS);
    localparam int STACK_DEPTH = 8;
    localparam int PTR_W = $clog2(STACK_DEPTH);
    localparam logic [PTR_W-1:0] STACK_STEP = 3'h1;
    localparam logic [ADDR_W-1:0] RESET_VEC = 13'h0000;
    localparam logic [ADDR_W-1:0] IRQ_VEC = 13'h0008;
    localparam logic [ADDR_W-1:0] PC_STEP = 13'h0001;
    localparam logic [7:0] BYTE_STEP = 8'h01;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [7:0] FLAG_RESET = 8'h00;
    localparam int CARRY_FLAG_BIT = 0;
    localparam int POWER_DOWN_FLAG_BIT = 6;
    localparam int TIMEOUT_FLAG_BIT = 7;
    // Cause flags as {timeout_flag, power_down_flag}
    localparam logic [1:0] CAUSE_FL_POR = 2'h2;
    localparam logic [1:0] CAUSE_FL_WDT = 2'h0;
    localparam logic [1:0] CAUSE_FL_EXT = 2'h3;

    typedef enum logic [1:0] {
        CAUSE_POWER_ON = 2'h0,
        CAUSE_WATCHDOG = 2'h1,
        CAUSE_EXTERNAL = 2'h2
    } pmvt_cause_t;

    typedef enum logic [3:0] {
        OP_NOP = 4'h0,
        OP_JMP = 4'h1,
        OP_LD_ACC = 4'h2,
        OP_LD_HI = 4'h3,
        OP_LD_LO = 4'h4,
        OP_INC_HI = 4'h5,
        OP_INC_LO = 4'h6,
        OP_BANK_ZERO_ADD = 4'h7,
        OP_SAVE_CTX = 4'h8,
        OP_RESTORE_CTX = 4'h9,
        OP_ROM_TABLE_READ = 4'hA,
        OP_INTERRUPT_RETURN = 4'hB,
        OP_WR_FLAG = 4'hC
    } pmvt_op_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_ADDR = 3'h2,
        ST_DATA = 3'h4
    } pmvt_state_t;

    typedef struct packed {
        logic valid;
        pmvt_op_t op;
        logic [ADDR_W-1:0] target;
        logic [7:0] data;
    } pmvt_cmd_t;

    typedef struct packed {
        logic [7:0] acc;
        logic [7:0] flags;
    } pmvt_ctx_t;
endpackage

// File: rtl/pmvt_ctx_buf.sv
// One-level shadow store for accumulator and flags.
// Assumes the caller raises save for one cycle per save instruction.
module pmvt_ctx_buf
    import pmvt_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Save request
    input wire logic save,
    input wire pmvt_ctx_t ctx_in,
    // Stored context
    output pmvt_ctx_t ctx_q
);
    // Single slot, no depth: nesting is the program's problem
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            ctx_q <= '0;
        else if (save)
            ctx_q <= ctx_in;
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);

    ctx_store_a: assert property (save |=> ctx_q == $past(ctx_in))
        else $error("Shadow did not take saved context");
    ctx_hold_a: assert property (!save |=> ctx_q == $past(ctx_q))
        else $error("Shadow changed without a save");
endmodule

// File: rtl/pmvt_pc_stack.sv
// Return address stack for interrupts.
// Assumes push and pop never come in the same cycle; overflow wraps silently.
module pmvt_pc_stack
    import pmvt_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Stack operations
    input wire logic push,
    input wire logic pop,
    input wire logic [ADDR_W-1:0] push_addr,
    // Top entry
    output logic [ADDR_W-1:0] top_addr
);
    logic [PTR_W-1:0] ptr_q;
    logic [ADDR_W-1:0] slot_q [STACK_DEPTH];

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            ptr_q <= '0;
        else if (push)
            ptr_q <= ptr_q + STACK_STEP;
        else if (pop)
            ptr_q <= ptr_q - STACK_STEP;
    end

    for (genvar i = 0; i < STACK_DEPTH; i++)
    begin : g_slot
        always_ff @(posedge clk_sys or posedge reset)
        begin
            if (reset)
                slot_q[i] <= '0;
            else if (push && ptr_q == PTR_W'(i))
                slot_q[i] <= push_addr;
        end
    end

    assign top_addr = slot_q[ptr_q - STACK_STEP];

    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);

    stack_push_pop_a: assert property (push ##1 pop |-> top_addr == $past(push_addr))
        else $error("Popped address differs from pushed one");
endmodule

// File: rtl/pmvt_prog_seq.sv
// Program counter, vectors, reset cause, context save and table read.
// Assumes the core decodes instructions into cmd_in and that the ROM
// returns rom_data_in one cycle after the address and read strobe.
module pmvt_prog_seq
    import pmvt_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Reset cause, valid at the first edge after release
    input wire pmvt_cause_t cause_in,
    // Decoded instruction and interrupt service request
    input wire pmvt_cmd_t cmd_in,
    input wire logic irq_take,
    // Program memory read port
    output logic [ADDR_W-1:0] rom_addr_q,
    output logic rom_rd_q,
    input wire logic [15:0] rom_data_in,
    // Core state
    output logic [ADDR_W-1:0] pc_q,
    output logic [7:0] acc_q,
    output logic [7:0] proc_flag_q,
    output logic [7:0] idx_hi_q,
    output logic [7:0] idx_lo_q,
    output logic [7:0] rom_hi_q,
    output logic busy_q,
    output logic irq_ack_q
);
    pmvt_state_t state_q;
    logic cap_done_q;
    logic idle_ok;
    logic irq_acc;
    logic cmd_acc;
    logic [8:0] lo_sum;
    logic [ADDR_W-1:0] stack_top;
    logic [15:0] tbl_addr;
    pmvt_ctx_t ctx_now;
    pmvt_ctx_t ctx_saved;

    function automatic logic [1:0] cause_flags(input pmvt_cause_t c);
        case (c)
            CAUSE_POWER_ON: cause_flags = CAUSE_FL_POR;
            CAUSE_WATCHDOG: cause_flags = CAUSE_FL_WDT;
            CAUSE_EXTERNAL: cause_flags = CAUSE_FL_EXT;
            default: cause_flags = CAUSE_FL_POR;
        endcase
    endfunction

    // New flag value with the reset-cause bits kept from the old one
    function automatic logic [7:0] keep_cause(input logic [7:0] nv, input logic [7:0] ov);
        logic [7:0] r;
        r = nv;
        r[TIMEOUT_FLAG_BIT] = ov[TIMEOUT_FLAG_BIT];
        r[POWER_DOWN_FLAG_BIT] = ov[POWER_DOWN_FLAG_BIT];
        return r;
    endfunction

    function automatic logic is_op(input pmvt_cmd_t c, input pmvt_op_t o);
        return c.op == o;
    endfunction

    // Interrupt wins over an instruction in the same cycle
    assign idle_ok = cap_done_q && state_q == ST_IDLE;
    assign irq_acc = idle_ok && irq_take;
    assign cmd_acc = idle_ok && !irq_take && cmd_in.valid;
    assign lo_sum = {1'b0, idx_lo_q} + {1'b0, acc_q};
    assign tbl_addr = {idx_hi_q, idx_lo_q};
    assign ctx_now = '{acc: acc_q, flags: proc_flag_q};

    pmvt_ctx_buf u_ctx (
        .clk_sys(clk_sys),
        .reset(reset),
        .save(cmd_acc && is_op(cmd_in, OP_SAVE_CTX)),
        .ctx_in(ctx_now),
        .ctx_q(ctx_saved)
    );

    pmvt_pc_stack u_stack (
        .clk_sys(clk_sys),
        .reset(reset),
        .push(irq_acc),
        .pop(cmd_acc && is_op(cmd_in, OP_INTERRUPT_RETURN)),
        .push_addr(pc_q),
        .top_addr(stack_top)
    );

    // Cause is sampled after release, never inside the async reset
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            cap_done_q <= 1'b0;
        else
            cap_done_q <= 1'b1;
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            pc_q <= RESET_VEC;
        else if (irq_acc)
            pc_q <= IRQ_VEC;
        else if (cmd_acc)
        begin
            case (cmd_in.op)
                OP_JMP: pc_q <= cmd_in.target;
                OP_INTERRUPT_RETURN: pc_q <= stack_top;
                default: pc_q <= pc_q + PC_STEP;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            irq_ack_q <= 1'b0;
        else
            irq_ack_q <= irq_acc;
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            proc_flag_q <= FLAG_RESET;
        else if (!cap_done_q)
            {proc_flag_q[TIMEOUT_FLAG_BIT], proc_flag_q[POWER_DOWN_FLAG_BIT]}
                <= cause_flags(cause_in);
        else if (cmd_acc)
        begin
            case (cmd_in.op)
                OP_BANK_ZERO_ADD: proc_flag_q[CARRY_FLAG_BIT] <= lo_sum[8];
                OP_WR_FLAG: proc_flag_q <= keep_cause(cmd_in.data, proc_flag_q);
                OP_RESTORE_CTX: proc_flag_q <= keep_cause(ctx_saved.flags, proc_flag_q);
                default: proc_flag_q <= proc_flag_q;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            acc_q <= BYTE_RESET;
        else if (state_q == ST_DATA)
            acc_q <= rom_data_in[7:0];
        else if (cmd_acc)
        begin
            case (cmd_in.op)
                OP_LD_ACC: acc_q <= cmd_in.data;
                OP_RESTORE_CTX: acc_q <= ctx_saved.acc;
                default: acc_q <= acc_q;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            rom_hi_q <= BYTE_RESET;
        else if (state_q == ST_DATA)
            rom_hi_q <= rom_data_in[15:8];
    end

    // The lower index never carries into the upper one by itself
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            idx_hi_q <= BYTE_RESET;
            idx_lo_q <= BYTE_RESET;
        end
        else if (cmd_acc)
        begin
            case (cmd_in.op)
                OP_LD_HI: idx_hi_q <= cmd_in.data;
                OP_LD_LO: idx_lo_q <= cmd_in.data;
                OP_INC_HI: idx_hi_q <= idx_hi_q + BYTE_STEP;
                OP_INC_LO: idx_lo_q <= idx_lo_q + BYTE_STEP;
                OP_BANK_ZERO_ADD: idx_lo_q <= lo_sum[7:0];
                default: idx_lo_q <= idx_lo_q;
            endcase
        end
    end

    // Table read: address cycle, data cycle, then back to idle
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            state_q <= ST_IDLE;
            rom_addr_q <= RESET_VEC;
            rom_rd_q <= 1'b0;
            busy_q <= 1'b1;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    if (cmd_acc && is_op(cmd_in, OP_ROM_TABLE_READ))
                    begin
                        state_q <= ST_ADDR;
                        // Only 8K words exist, upper index bits 5-7 (address bits 13-15) drop out
                        rom_addr_q <= tbl_addr[ADDR_W-1:0];
                        rom_rd_q <= 1'b1;
                        busy_q <= 1'b1;
                    end
                    else
                    begin
                        rom_rd_q <= 1'b0;
                        busy_q <= 1'b0;
                    end
                end
                ST_ADDR:
                begin
                    state_q <= ST_DATA;
                    rom_rd_q <= 1'b0;
                    busy_q <= 1'b1;
                end
                ST_DATA:
                begin
                    state_q <= ST_IDLE;
                    busy_q <= 1'b0;
                end
                default:
                begin
                    state_q <= ST_IDLE;
                    rom_rd_q <= 1'b0;
                    busy_q <= 1'b0;
                end
            endcase
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);

    sequence tbl_issue_s;
        rom_rd_q && rom_addr_q == $past(tbl_addr[ADDR_W-1:0]);
    endsequence

    sequence tbl_land_s;
        acc_q == $past(rom_data_in[7:0]) && rom_hi_q == $past(rom_data_in[15:8]) && !busy_q;
    endsequence

    reset_vector_a: assert property (!cap_done_q |-> pc_q == RESET_VEC && acc_q == BYTE_RESET)
        else $error("Program counter not at reset vector after reset");
    cause_capture_a: assert property ($rose(cap_done_q) |->
        {proc_flag_q[TIMEOUT_FLAG_BIT], proc_flag_q[POWER_DOWN_FLAG_BIT]}
        == cause_flags($past(cause_in)))
        else $error("Reset cause flags wrong");
    cause_stable_a: assert property (cap_done_q && $past(cap_done_q) |->
        $stable(proc_flag_q[TIMEOUT_FLAG_BIT]) && $stable(proc_flag_q[POWER_DOWN_FLAG_BIT]))
        else $error("Reset cause flags changed during run");
    irq_vector_a: assert property (irq_acc |=>
        pc_q == IRQ_VEC && stack_top == $past(pc_q) && irq_ack_q)
        else $error("Interrupt entry did not push and vector");
    irq_return_a: assert property (cmd_acc && is_op(cmd_in, OP_INTERRUPT_RETURN) |=>
        pc_q == $past(stack_top))
        else $error("Interrupt return did not resume at popped address");
    table_read_a: assert property (cmd_acc && is_op(cmd_in, OP_ROM_TABLE_READ) |=>
        tbl_issue_s ##1 (busy_q && !rom_rd_q) ##1 tbl_land_s)
        else $error("Table read sequence wrong");
    lo_wrap_a: assert property (cmd_acc && is_op(cmd_in, OP_INC_LO) |=>
        idx_hi_q == $past(idx_hi_q) && idx_lo_q == $past(idx_lo_q) + BYTE_STEP)
        else $error("Lower index increment touched upper index");
    add_carry_a: assert property (cmd_acc && is_op(cmd_in, OP_BANK_ZERO_ADD) |=>
        proc_flag_q[CARRY_FLAG_BIT] == ({1'b0, $past(idx_lo_q)} + {1'b0, $past(acc_q)} > 9'h0FF))
        else $error("Carry wrong after index add");
    restore_ctx_a: assert property (cmd_acc && is_op(cmd_in, OP_RESTORE_CTX) |=>
        acc_q == $past(ctx_saved.acc))
        else $error("Restore did not return saved accumulator");

    // Commands offered while busy must leave no trace
    sequence idx_still_s;
        $stable(idx_hi_q) && $stable(idx_lo_q);
    endsequence

    busy_idx_a: assert property (!idle_ok |=> idx_still_s)
        else $error("Index registers moved during a table read");
    busy_pc_a: assert property (!idle_ok |=> $stable(pc_q) && !irq_ack_q)
        else $error("Program counter or interrupt moved while busy");
    rom_strobe_a: assert property (rom_rd_q |=> !rom_rd_q && $stable(rom_addr_q))
        else $error("Table read strobe longer than one cycle");
    wr_flag_a: assert property (cmd_acc && is_op(cmd_in, OP_WR_FLAG) |=>
        proc_flag_q[POWER_DOWN_FLAG_BIT-1:0] == $past(cmd_in.data[POWER_DOWN_FLAG_BIT-1:0]))
        else $error("Flag write did not land");
    restore_flags_a: assert property (cmd_acc && is_op(cmd_in, OP_RESTORE_CTX) |=>
        proc_flag_q[POWER_DOWN_FLAG_BIT-1:0] == $past(ctx_saved.flags[POWER_DOWN_FLAG_BIT-1:0]))
        else $error("Restore did not return saved flags");
    save_ctx_a: assert property (cmd_acc && is_op(cmd_in, OP_SAVE_CTX) |=>
        ctx_saved == $past(ctx_now))
        else $error("Save did not overwrite the shadow");
    inc_hi_a: assert property (cmd_acc && is_op(cmd_in, OP_INC_HI) |=>
        idx_hi_q == $past(idx_hi_q) + BYTE_STEP && idx_lo_q == $past(idx_lo_q))
        else $error("Upper index increment wrong");
    add_sum_a: assert property (cmd_acc && is_op(cmd_in, OP_BANK_ZERO_ADD) |=>
        idx_lo_q == $past(idx_lo_q) + $past(acc_q) && idx_hi_q == $past(idx_hi_q))
        else $error("Index add sum wrong");
    irq_wins_a: assert property (irq_acc |=>
        acc_q == $past(acc_q) && idx_lo_q == $past(idx_lo_q) && idx_hi_q == $past(idx_hi_q))
        else $error("Instruction ran alongside an interrupt");
    pc_advance_a: assert property (cmd_acc && !is_op(cmd_in, OP_JMP) &&
        !is_op(cmd_in, OP_INTERRUPT_RETURN) |=> pc_q == $past(pc_q) + PC_STEP)
        else $error("Program counter did not step one word");
    jump_target_a: assert property (cmd_acc && is_op(cmd_in, OP_JMP) |=>
        pc_q == $past(cmd_in.target))
        else $error("Jump did not reach its target");
endmodule

// File: tb/pmvt_prog_seq_tb.sv
// Self-checking bench for the program sequencer.
// Assumes the package from include/ and a one-cycle synchronous ROM, modelled here.
module pmvt_prog_seq_tb
    import pmvt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_sys;
    logic reset;
    logic irq_take;
    pmvt_cause_t cause_in;
    pmvt_cmd_t cmd_in;
    logic [15:0] rom_data_in;
    logic [ADDR_W-1:0] rom_addr_q;
    logic [ADDR_W-1:0] pc_q;
    logic rom_rd_q;
    logic busy_q;
    logic irq_ack_q;
    logic [7:0] acc_q;
    logic [7:0] proc_flag_q;
    logic [7:0] idx_hi_q;
    logic [7:0] idx_lo_q;
    logic [7:0] rom_hi_q;
    int err_total = 0;
    int samples_checked = 0;
    int cyc = 0;
    int unsigned seed_v;
    // Reference state
    logic [ADDR_W-1:0] m_pc;
    logic [7:0] m_acc;
    logic [7:0] m_fl;
    logic [7:0] m_hi;
    logic [7:0] m_lo;
    logic [7:0] m_rh;
    pmvt_ctx_t m_sh;
    logic [ADDR_W-1:0] m_stk[$];
    int due_q[$];
    logic [54:0] exp_q[$];
    pmvt_cause_t cs[3] = '{CAUSE_POWER_ON, CAUSE_EXTERNAL, CAUSE_WATCHDOG};
    logic [1:0] fb[3] = '{2'h2, 2'h3, 2'h0};
    wire logic [54:0] obs_v = {busy_q, irq_ack_q, pc_q, acc_q, proc_flag_q, idx_hi_q,
        idx_lo_q, rom_hi_q};

    pmvt_prog_seq pmvt_prog_seq_i (
        .clk_sys(clk_sys),
        .reset(reset),
        .cause_in(cause_in),
        .cmd_in(cmd_in),
        .irq_take(irq_take),
        .rom_addr_q(rom_addr_q),
        .rom_rd_q(rom_rd_q),
        .rom_data_in(rom_data_in),
        .pc_q(pc_q),
        .acc_q(acc_q),
        .proc_flag_q(proc_flag_q),
        .idx_hi_q(idx_hi_q),
        .idx_lo_q(idx_lo_q),
        .rom_hi_q(rom_hi_q),
        .busy_q(busy_q),
        .irq_ack_q(irq_ack_q)
    );

    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) cyc <= cyc + 1;

    function automatic logic [15:0] rom_word(input logic [12:0] a);
        return {a[4:0], a[12:10], a[7:0] ^ 8'h3C};
    endfunction

    // Outside a read the data toggles, so a late sample never matches
    always @(posedge clk_sys) rom_data_in <= rom_rd_q ? rom_word(rom_addr_q) : ~rom_data_in;

    function automatic logic [54:0] snap(input logic ack);
        return {1'b0, ack, m_pc, m_acc, m_fl, m_hi, m_lo, m_rh};
    endfunction

    task automatic chk(input logic [54:0] seen, input logic [54:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("ERROR %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("comparisons %0d, mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Oldest note is compared once its due cycle has arrived
    always @(negedge clk_sys)
    begin
        while (due_q.size() > 0 && due_q[0] == cyc)
        begin
            chk(obs_v, exp_q.pop_front());
            void'(due_q.pop_front());
        end
    end

    task automatic rst(input pmvt_cause_t c, input logic [1:0] f);
        @(negedge clk_sys);
        reset = 1'b1;
        cause_in = c;
        irq_take = 1'b0;
        cmd_in = '0;
        repeat (16) @(negedge clk_sys);
        chk(55'({busy_q, rom_rd_q, pc_q}), 55'({2'b10, 13'h0000}));
        reset = 1'b0;
        m_pc = 13'h0000;
        m_acc = 8'h00;
        m_fl = {f, 6'h00};
        m_hi = 8'h00;
        m_lo = 8'h00;
        m_rh = 8'h00;
        m_sh = '0;
        m_stk.delete();
        due_q.delete();
        exp_q.delete();
        @(negedge clk_sys);
        chk(obs_v, snap(1'b0));
    endtask

    task automatic op(input pmvt_op_t o, input logic [12:0] t, input logic [7:0] d);
        logic [8:0] sum;
        logic [15:0] w;
        @(negedge clk_sys);
        irq_take = 1'b0;
        cmd_in = {1'b1, o, t, d};
        m_pc = m_pc + 13'h0001;
        case (o)
            OP_JMP: m_pc = t;
            OP_LD_ACC: m_acc = d;
            OP_LD_HI: m_hi = d;
            OP_LD_LO: m_lo = d;
            OP_INC_HI: m_hi = m_hi + 8'h01;
            OP_INC_LO: m_lo = m_lo + 8'h01;
            OP_BANK_ZERO_ADD:
            begin
                sum = {1'b0, m_lo} + {1'b0, m_acc};
                m_lo = sum[7:0];
                m_fl[0] = sum[8];
            end
            OP_SAVE_CTX: m_sh = {m_acc, m_fl};
            OP_RESTORE_CTX:
            begin
                m_acc = m_sh.acc;
                m_fl = {m_fl[7:6], m_sh.flags[5:0]};
            end
            OP_WR_FLAG: m_fl = {m_fl[7:6], d[5:0]};
            OP_INTERRUPT_RETURN: m_pc = m_stk.pop_back();
            OP_ROM_TABLE_READ:
            begin
                w = rom_word({m_hi[4:0], m_lo});
                m_acc = w[7:0];
                m_rh = w[15:8];
            end
            default: ;
        endcase
        due_q.push_back(cyc + ((o == OP_ROM_TABLE_READ) ? 3 : 1));
        exp_q.push_back(snap(1'b0));
        if (o == OP_ROM_TABLE_READ)
        begin
            // A load offered while busy must leave no trace
            @(negedge clk_sys);
            cmd_in = {1'b1, OP_LD_ACC, 13'h0000, 8'hEE};
            chk(55'({rom_rd_q, rom_addr_q}), 55'({1'b1, m_hi[4:0], m_lo}));
            @(negedge clk_sys);
            chk(55'({busy_q, rom_rd_q}), 55'(2'b10));
        end
    endtask

    task automatic irq();
        @(negedge clk_sys);
        irq_take = 1'b1;
        cmd_in = {1'b1, OP_LD_ACC, 13'h0000, 8'h77};
        m_stk.push_back(m_pc);
        m_pc = 13'h0008;
        due_q.push_back(cyc + 1);
        exp_q.push_back(snap(1'b1));
        // Left up for the next call to drop, so a return can follow at once
    endtask

    initial
    begin
        reset = 1'b1;
        cause_in = CAUSE_POWER_ON;
        cmd_in = '0;
        irq_take = 1'b0;
        rom_data_in = 16'h0000;
        seed_v = $urandom(32'h0214);
        // Each pass starts with a reset of another cause, mid-run for all but the first
        for (int i = 0; i < 3; i++)
        begin
            rst(cs[i], fb[i]);
            $display("reset cause %0d test done", i);
            op(OP_WR_FLAG, 13'h0000, 8'hFF);
            op(OP_LD_ACC, 13'h0000, 8'($urandom));
            op(OP_SAVE_CTX, 13'h0000, 8'h00);
            op(OP_LD_ACC, 13'h0000, 8'($urandom));
            op(OP_WR_FLAG, 13'h0000, 8'h15);
            op(OP_SAVE_CTX, 13'h0000, 8'h00);
            op(OP_LD_ACC, 13'h0000, 8'h00);
            op(OP_WR_FLAG, 13'h0000, 8'hFF);
            op(OP_RESTORE_CTX, 13'h0000, 8'h00);
            $display("context test done");
            op(OP_LD_LO, 13'h0000, 8'hFF);
            op(OP_LD_HI, 13'h0000, 8'h12);
            op(OP_INC_LO, 13'h0000, 8'h00);
            op(OP_INC_HI, 13'h0000, 8'h00);
            op(OP_LD_ACC, 13'h0000, 8'h01);
            op(OP_LD_LO, 13'h0000, 8'hFF);
            op(OP_BANK_ZERO_ADD, 13'h0000, 8'h00);
            op(OP_BANK_ZERO_ADD, 13'h0000, 8'h00);
            repeat (6)
            begin
                op(OP_LD_ACC, 13'h0000, 8'($urandom));
                op(OP_LD_LO, 13'h0000, 8'($urandom));
                op(OP_BANK_ZERO_ADD, 13'h0000, 8'h00);
            end
            $display("index test done");
            repeat (5)
            begin
                op(OP_LD_HI, 13'h0000, 8'($urandom));
                op(OP_LD_LO, 13'h0000, 8'($urandom));
                op(OP_ROM_TABLE_READ, 13'h0000, 8'h00);
            end
            op(OP_INC_LO, 13'h0000, 8'h00);
            op(OP_ROM_TABLE_READ, 13'h0000, 8'h00);
            $display("table read test done");
            op(OP_JMP, 13'h1234, 8'h00);
            irq();
            op(OP_NOP, 13'h0000, 8'h00);
            irq();
            op(OP_INTERRUPT_RETURN, 13'h0000, 8'h00);
            op(OP_INTERRUPT_RETURN, 13'h0000, 8'h00);
            op(OP_NOP, 13'h0000, 8'h00);
            $display("interrupt test done");
        end
        @(negedge clk_sys);
        cmd_in = '0;
        repeat (4) @(negedge clk_sys);
        chk(55'(due_q.size()), 55'(0));
        end_sim();
    end

    // Hang guard
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        $display("ERROR %0t: run did not finish", $time);
        end_sim();
    end
endmodule
